// File: pad_cell_ctl.sv
`timescale 1ns/100ps
// final pad driver: applies reset, hibernate and deep sleep overrides
module pad_cell_ctl
  import pad_mux_pkg::*;
(
  // power state
  input wire logic reset_input_low_sync,
  input wire logic hibernate,
  input wire logic deep_sleep_state,
  // sleep configuration
  input wire logic [1:0] sleep_mode,
  input wire logic sleep_level,
  input wire logic sleep_forced_valid,
  input wire logic sleep_forced_level,
  // active-mode drive
  input wire logic act_out,
  input wire logic act_oe_n,
  // pad
  output logic pad_out,
  output logic pad_oe_n,
  output logic pad_pull
);
  always_comb begin
    pad_out = act_out;
    pad_oe_n = act_oe_n;
    pad_pull = 1'b0;
    if (!reset_input_low_sync) begin
      pad_oe_n = 1'b1;
      pad_out = 1'b0;
    end else if (hibernate || (deep_sleep_state && !sleep_forced_valid)) begin
      pad_out = sleep_level;
      pad_oe_n = (sleep_mode != PS_DRIVE);
      pad_pull = (sleep_mode == PS_PULL);
    end else if (deep_sleep_state) begin
      pad_out = sleep_forced_level;
      pad_oe_n = 1'b0;
    end
  end
endmodule

// File: pad_far_side_model.sv
`timescale 1ns/100ps
// far side of the mux: peripheral outputs and the board wiring on the pads
module pad_far_side_model (
  // clock
  input wire logic core_clk,
  // pad side
  input wire logic [4:0] pad_out,
  input wire logic [4:0] pad_oe_n,
  input wire logic [4:0] board_lvl,
  output logic [4:0] pad_in,
  // peripheral side
  output logic [4:0] gpio_out,
  output logic [13:0] pp
);
  logic tgl_r = 1'h0;
  // every source flips each cycle; gpio bits differ from their neighbours, pp bits follow the fixed 25c3 pattern
  always_ff @(posedge core_clk) begin
    tgl_r <= ~tgl_r;
  end
  assign pp = 14'h25c3 ^ {14{tgl_r}};
  assign gpio_out = 5'h15 ^ {5{tgl_r}};
  // wire level: the pad's own drive wins, a released pad shows the board level
  assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & board_lvl);
endmodule

// File: pad_function_mux.sv
`timescale 1ns/100ps
// Overview of operation
// - pad4 gpio,hsync,i2c data,rx0,cap4
// - pad5 gpio,data4,i2c clk,spi clk,cap5
// - i2c pads open drain, never high outside deep sleep and hibernate
// - deep sleep fixed or configurable levels
// - hibernate configurable, reset makes hi-z
// - oscillator enable pad driven high, driven low while reset pin low
// - hibernate: enable pad hi-z pulled down
// - boot enables digital path automatically
// - adc switch off until configured
module pad_function_mux
  import pad_mux_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // pad pins and power state
  input wire logic reset_input_low,
  input wire logic hibernate,
  input wire logic deep_sleep_state,
  input wire logic [NUM_PADS-1:0] pad_in,
  output logic [NUM_PADS-1:0] pad_out,
  output logic [NUM_PADS-1:0] pad_oe_n,
  output logic [NUM_PADS-1:0] pad_pull,
  // configuration
  input wire logic sel_we,
  input wire logic [2:0] sel_pad,
  input wire logic [3:0] sel_value,
  output logic [4*NUM_PADS-1:0] sel_state,
  input wire logic [2*NUM_PADS-1:0] sleep_mode,
  input wire logic [NUM_PADS-1:0] sleep_level,
  input wire logic adc_switch_req,
  output logic adc_switch_on,
  output logic digital_path_en,
  // oscillator enable pad
  output logic osc_enable_out,
  output logic osc_enable_oe_n,
  output logic osc_enable_pull_down,
  // peripheral outputs toward the pads
  input wire logic [NUM_PADS-1:0] gpio_out,
  input wire logic [NUM_PADS-1:0] gpio_oe_n,
  input wire logic i2c_scl_low,
  input wire logic i2c_sda_low,
  input wire logic timer_pwm_ch6,
  input wire logic timer_pwm_ch7,
  input wire logic card_clock_out,
  input wire logic card_command_out,
  input wire logic card_command_oe_n,
  input wire logic serial_port1_transmit,
  input wire logic serial_port0_transmit,
  input wire logic camera_pixel_clock_out,
  input wire logic audio_bit_clock,
  input wire logic audio_frame_sync,
  input wire logic generic_serial_clock,
  input wire logic generic_serial_clock_oe_n,
  // pad inputs toward the peripherals
  output logic [NUM_PADS-1:0] gpio_in,
  output logic i2c_scl_in,
  output logic i2c_sda_in,
  output logic card_command_line,
  output logic serial_port1_receive,
  output logic serial_port0_receive,
  output logic camera_vertical_sync_in,
  output logic camera_horizontal_sync_in,
  output logic camera_data_bit4_in,
  output logic generic_serial_clock_in,
  output logic timer_capture_ch1,
  output logic timer_capture_ch2,
  output logic timer_capture_ch3,
  output logic timer_capture_ch4,
  output logic timer_capture_ch5
);
  logic [3:0] sel_r [NUM_PADS];
  logic [NUM_PADS-1:0] in_s1_r;
  logic [NUM_PADS-1:0] in_s2_r;
  logic nrst_s1_r;
  logic nrst_s2_r;
  logic adc_r;
  logic boot_r;
  logic [NUM_PADS-1:0] act_out;
  logic [NUM_PADS-1:0] act_oe_n;
  logic [NUM_PADS-1:0] force_v;
  logic [NUM_PADS-1:0] force_l;

  // pins pass two flops before any logic reads them
  always_ff @(posedge core_clk) begin
    in_s1_r <= pad_in;
    in_s2_r <= in_s1_r;
    nrst_s1_r <= reset_input_low;
    nrst_s2_r <= nrst_s1_r;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < NUM_PADS; i++) sel_r[i] <= SEL_RESET;
    end else if (sel_we && sel_pad < 3'(NUM_PADS)) begin
      sel_r[sel_pad] <= sel_value;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) boot_r <= 1'b0;
    else boot_r <= 1'b1;
  end
  assign digital_path_en = boot_r;

  // adc switch default off; closes only on request
  // switch held open unless pad4 digital driver is off
  always_ff @(posedge core_clk) begin
    if (reset) adc_r <= 1'b0;
    else adc_r <= adc_switch_req && act_oe_n[3];
  end
  assign adc_switch_on = adc_r;

  always_comb begin
    for (int i = 0; i < NUM_PADS; i++) sel_state[4*i +: 4] = sel_r[i];
  end

  assign osc_enable_out = !hibernate && nrst_s2_r;
  assign osc_enable_oe_n = hibernate;
  assign osc_enable_pull_down = hibernate;

  // active-mode output decode; unlisted codes leave the pad undriven
  always_comb begin
    act_out = '0;
    act_oe_n = '1;
    force_v = '0;
    force_l = '0;
    for (int i = 0; i < NUM_PADS; i++) begin
      if (sel_r[i] == SEL_GPIO) begin
        act_out[i] = gpio_out[i];
        act_oe_n[i] = gpio_oe_n[i];
      end
    end
    case (sel_r[0])
      SEL_1: act_oe_n[0] = !i2c_scl_low;
      SEL_3: begin act_out[0] = timer_pwm_ch6; act_oe_n[0] = 1'b0; end
      SEL_6: begin act_out[0] = card_clock_out; act_oe_n[0] = 1'b0; force_v[0] = 1'b1; end
      SEL_7: begin
        act_out[0] = serial_port1_transmit;
        act_oe_n[0] = 1'b0;
        force_v[0] = 1'b1;
        force_l[0] = 1'b1;
      end
      default: ;
    endcase
    case (sel_r[1])
      SEL_1: act_oe_n[1] = !i2c_sda_low;
      SEL_3: begin act_out[1] = timer_pwm_ch7; act_oe_n[1] = 1'b0; end
      SEL_4: begin
        act_out[1] = camera_pixel_clock_out;
        act_oe_n[1] = 1'b0;
        force_v[1] = 1'b1;
      end
      SEL_6: begin act_out[1] = 1'b0; act_oe_n[1] = card_command_oe_n | card_command_out; end
      SEL_13: begin act_out[1] = audio_frame_sync; act_oe_n[1] = 1'b0; end
      default: ;
    endcase
    case (sel_r[2])
      SEL_3: begin act_out[2] = audio_bit_clock; act_oe_n[2] = 1'b0; end
      SEL_5: act_oe_n[2] = !i2c_scl_low;
      SEL_7: begin
        act_out[2] = serial_port0_transmit;
        act_oe_n[2] = 1'b0;
        force_v[2] = 1'b1;
        force_l[2] = 1'b1;
      end
      default: ;
    endcase
    if (sel_r[3] == SEL_5) act_oe_n[3] = !i2c_sda_low;
    case (sel_r[4])
      SEL_5: act_oe_n[4] = !i2c_scl_low;
      SEL_7: begin act_out[4] = generic_serial_clock; act_oe_n[4] = generic_serial_clock_oe_n; end
      default: ;
    endcase
  end

  // input routing, idle values when not selected
  // registered so peripheral data comes from flops
  always_ff @(posedge core_clk) begin
    if (reset) begin
      gpio_in <= '0;
      i2c_scl_in <= 1'b1;
      i2c_sda_in <= 1'b1;
      card_command_line <= 1'b1;
      serial_port1_receive <= 1'b1;
      serial_port0_receive <= 1'b1;
      camera_vertical_sync_in <= 1'b0;
      camera_horizontal_sync_in <= 1'b0;
      camera_data_bit4_in <= 1'b0;
      generic_serial_clock_in <= 1'b0;
      timer_capture_ch1 <= 1'b0;
      timer_capture_ch2 <= 1'b0;
      timer_capture_ch3 <= 1'b0;
      timer_capture_ch4 <= 1'b0;
      timer_capture_ch5 <= 1'b0;
    end else begin
      for (int i = 0; i < NUM_PADS; i++) begin
        gpio_in[i] <= (sel_r[i] == SEL_GPIO) ? in_s2_r[i] : 1'b0;
      end
      // several pads may carry scl; any low one pulls the line low
      i2c_scl_in <= !((sel_r[0] == SEL_1 && !in_s2_r[0]) || (sel_r[2] == SEL_5 && !in_s2_r[2])
                      || (sel_r[4] == SEL_5 && !in_s2_r[4]));
      i2c_sda_in <= !((sel_r[1] == SEL_1 && !in_s2_r[1]) || (sel_r[3] == SEL_5 && !in_s2_r[3]));
      card_command_line <= (sel_r[1] == SEL_6) ? in_s2_r[1] : 1'b1;
      serial_port1_receive <= (sel_r[1] == SEL_7) ? in_s2_r[1] : 1'b1;
      serial_port0_receive <= (sel_r[3] == SEL_7) ? in_s2_r[3] : 1'b1;
      camera_vertical_sync_in <= (sel_r[2] == SEL_4) && in_s2_r[2];
      camera_horizontal_sync_in <= (sel_r[3] == SEL_4) && in_s2_r[3];
      camera_data_bit4_in <= (sel_r[4] == SEL_4) && in_s2_r[4];
      generic_serial_clock_in <= (sel_r[4] == SEL_7) && in_s2_r[4];
      timer_capture_ch1 <= (sel_r[0] == SEL_12) && in_s2_r[0];
      timer_capture_ch2 <= (sel_r[1] == SEL_12) && in_s2_r[1];
      timer_capture_ch3 <= (sel_r[2] == SEL_12) && in_s2_r[2];
      timer_capture_ch4 <= (sel_r[3] == SEL_12) && in_s2_r[3];
      timer_capture_ch5 <= (sel_r[4] == SEL_12) && in_s2_r[4];
    end
  end

  // per-pad power-state overrides
  for (genvar g = 0; g < NUM_PADS; g++) begin : g_pad
    pad_cell_ctl u_cell (
      .reset_input_low_sync(nrst_s2_r),
      .hibernate(hibernate),
      .deep_sleep_state(deep_sleep_state),
      .sleep_mode(sleep_mode[2*g +: 2]),
      .sleep_level(sleep_level[g]),
      .sleep_forced_valid(force_v[g]),
      .sleep_forced_level(force_l[g]),
      .act_out(act_out[g]),
      .act_oe_n(act_oe_n[g]),
      .pad_out(pad_out[g]),
      .pad_oe_n(pad_oe_n[g]),
      .pad_pull(pad_pull[g])
    );
  end

  a_i2c_open_drain: assert property (@(posedge core_clk) disable iff (reset)
    (sel_r[0] == SEL_1 && !pad_oe_n[0] && !deep_sleep_state && !hibernate) |-> !pad_out[0])
    else $error("i2c pad driven high");
  a_sel_reset: assert property (@(posedge core_clk) $fell(reset) |-> sel_r[0] == SEL_GPIO)
    else $error("encoding not gpio after reset");
  a_adc_reset: assert property (@(posedge core_clk) $fell(reset) |-> !adc_switch_on)
    else $error("adc switch on after reset");
  a_adc_hiz: assert property (@(posedge core_clk) disable iff (reset)
    adc_switch_on |-> $past(act_oe_n[3]))
    else $error("adc closed with pad driven");
  a_osc_hib: assert property (@(posedge core_clk)
    hibernate |-> osc_enable_oe_n && osc_enable_pull_down)
    else $error("oscillator pad not released");
  // tx held high on either transmit pad
  a_sleep_tx: assert property (@(posedge core_clk) disable iff (reset)
    (deep_sleep_state && !hibernate && nrst_s2_r && (sel_r[0] == SEL_7 || sel_r[2] == SEL_7))
    |-> (sel_r[0] != SEL_7 || (pad_out[0] && !pad_oe_n[0]))
    && (sel_r[2] != SEL_7 || (pad_out[2] && !pad_oe_n[2])))
    else $error("transmit pad not high in sleep");
  a_reset_hiz: assert property (@(posedge core_clk) !nrst_s2_r |-> &pad_oe_n)
    else $error("pad driven during reset");
  a_unsel_idle: assert property (@(posedge core_clk) disable iff (reset)
    $past(sel_r[0]) != SEL_12 |-> !timer_capture_ch1)
    else $error("capture active while unselected");
endmodule

// File: pad_function_mux_tb.sv
`timescale 1ns/100ps
// bench for the pad mux: writes encodings, then watches the pad and peripheral sides
module pad_function_mux_tb;
  import pad_mux_pkg::*;
  logic core_clk = 1'h0, reset = 1'h1, reset_input_low = 1'h1;
  logic hibernate = 1'h0, deep_sleep_state = 1'h0, sel_we = 1'h0, adc_switch_req = 1'h0;
  logic adc_switch_on, digital_path_en, osc_enable_out, osc_enable_oe_n, osc_enable_pull_down;
  logic [2:0] sel_pad = 3'h0;
  logic [3:0] sel_value = 4'h0;
  logic [19:0] sel_state;
  logic [9:0] sleep_mode = 10'h0;
  logic [4:0] sleep_level = 5'h0, board_lvl = 5'h0, gpio_oe_n = 5'h1f;
  logic [4:0] pad_in, pad_out, pad_oe_n, pad_pull, gpio_out;
  logic [13:0] pp;
  wire [13:0] ins;
  logic [4:0] gpio_in;
  int bad_count = 0, num_checks = 0;
  // {pad, code, source}: driven functions
  logic [11:0] otab [9] = '{12'h032, 12'h064, 12'h077, 12'h133, 12'h149, 12'h1db, 12'h23a,
    12'h278, 12'h47c};
  // {pad, code, peripheral input}: received functions
  logic [11:0] itab [11] = '{12'h0c9, 12'h162, 12'h173, 12'h1ca, 12'h245, 12'h2cb, 12'h346,
    12'h374, 12'h3cc, 12'h447, 12'h4cd};

  pad_function_mux dut (
    .core_clk, .reset, .reset_input_low, .hibernate, .deep_sleep_state, .pad_in, .pad_out,
    .pad_oe_n, .pad_pull, .sel_we, .sel_pad, .sel_value, .sel_state, .sleep_mode, .sleep_level,
    .adc_switch_req, .adc_switch_on, .digital_path_en, .osc_enable_out, .osc_enable_oe_n,
    .osc_enable_pull_down, .gpio_out, .gpio_oe_n, .i2c_scl_low(pp[0]), .i2c_sda_low(pp[1]),
    .timer_pwm_ch6(pp[2]), .timer_pwm_ch7(pp[3]), .card_clock_out(pp[4]),
    .card_command_out(pp[5]), .card_command_oe_n(pp[6]), .serial_port1_transmit(pp[7]),
    .serial_port0_transmit(pp[8]), .camera_pixel_clock_out(pp[9]), .audio_bit_clock(pp[10]),
    .audio_frame_sync(pp[11]), .generic_serial_clock(pp[12]),
    .generic_serial_clock_oe_n(pp[13]), .gpio_in, .i2c_scl_in(ins[0]), .i2c_sda_in(ins[1]),
    .card_command_line(ins[2]), .serial_port1_receive(ins[3]), .serial_port0_receive(ins[4]),
    .camera_vertical_sync_in(ins[5]), .camera_horizontal_sync_in(ins[6]),
    .camera_data_bit4_in(ins[7]), .generic_serial_clock_in(ins[8]),
    .timer_capture_ch1(ins[9]), .timer_capture_ch2(ins[10]), .timer_capture_ch3(ins[11]),
    .timer_capture_ch4(ins[12]), .timer_capture_ch5(ins[13]));

  pad_far_side_model far (.core_clk, .pad_out, .pad_oe_n, .board_lvl, .pad_in, .gpio_out, .pp);

  // clock
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic chk(input string what, input logic [19:0] seen, input logic [19:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one encoding write, launched and dropped on falling edges
  task automatic wr(input logic [2:0] p, input logic [3:0] v);
    @(negedge core_clk);
    sel_we = 1'h1;
    sel_pad = p;
    sel_value = v;
    @(negedge core_clk);
    sel_we = 1'h0;
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // watchdog: the tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge core_clk);
    bad_count++;
    stop_test();
  end

  initial begin
    repeat (4) @(negedge core_clk);
    reset = 1'h0;
    @(negedge core_clk);
    // state after reset; oscillator pad only ever observed
    chk("sel_state", sel_state, 20'h0);
    chk("digital_path_en", digital_path_en, 1'h1);
    chk("adc_switch_on", adc_switch_on, 1'h0);
    chk("osc enable", {osc_enable_out, osc_enable_oe_n}, 2'h2);
    chk("idle rx", ins[4:3], 2'h3);
    foreach (otab[i]) begin
      wr(otab[i][10:8], otab[i][7:4]);
      repeat (2) begin
        @(negedge core_clk);
        chk("pad_out", pad_out[otab[i][10:8]], pp[otab[i][3:0]]);
        chk("pad_oe_n", pad_oe_n[otab[i][10:8]], otab[i][3:0] == 4'hc ? pp[13] : 1'h0);
      end
    end
    foreach (itab[i]) begin
      wr(itab[i][10:8], itab[i][7:4]);
      for (int b = 1; b >= 0; b--) begin
        board_lvl[itab[i][10:8]] = b[0];
        repeat (5) @(negedge core_clk);
        chk("periph in", ins[itab[i][3:0]], b[0]);
      end
    end
    // clock and data lines on every pad only pull low or let go
    for (int p = 0; p < 5; p++) begin
      wr(p[2:0], p < 2 ? SEL_1 : SEL_5);
      repeat (2) begin
        @(negedge core_clk);
        chk("open drain", {pad_oe_n[p], pad_out[p] & ~pad_oe_n[p]}, {~pp[p % 2], 1'h0});
      end
    end
    // unlisted code and pad number out of range
    wr(3'h3, 4'h3);
    wr(3'h5, SEL_7);
    repeat (5) @(negedge core_clk);
    chk("unlisted", {pad_oe_n[3], ins[12], ins[4], ins[6], ins[1:0]}, 6'h28);
    chk("sel_state", sel_state, 20'h53511);
    // deep sleep fixed and configured levels
    wr(3'h0, SEL_7);
    wr(3'h1, SEL_4);
    wr(3'h2, SEL_3);
    sleep_mode = 10'h060;
    sleep_level = 5'h04;
    deep_sleep_state = 1'h1;
    repeat (3) @(negedge core_clk);
    chk("deep sleep", {pad_out[2:0], pad_oe_n[3:0]}, 7'h58);
    wr(3'h0, SEL_6);
    chk("card clk sleep", {pad_out[0], pad_oe_n[0]}, 2'h0);
    hibernate = 1'h1;
    repeat (3) @(negedge core_clk);
    chk("hib osc", {osc_enable_out, osc_enable_oe_n, osc_enable_pull_down}, 3'h3);
    chk("hib pad", {pad_out[2], pad_oe_n[2]}, 2'h2);
    chk("hib pull", pad_pull, 5'h08);
    sleep_level = 5'h0;
    @(negedge core_clk);
    chk("hib pad", {pad_out[2], pad_oe_n[2]}, 2'h0);
    hibernate = 1'h0;
    deep_sleep_state = 1'h0;
    reset_input_low = 1'h0;
    repeat (4) @(negedge core_clk);
    chk("pin reset", pad_oe_n, 5'h1f);
    reset_input_low = 1'h1;
    // analog switch waits for the pad to be released
    wr(3'h3, SEL_GPIO);
    gpio_oe_n = 5'h17;
    adc_switch_req = 1'h1;
    repeat (3) @(negedge core_clk);
    chk("adc held", {pad_out[3] ^ gpio_out[3], adc_switch_on}, 2'h0);
    gpio_oe_n = 5'h1f;
    repeat (3) @(negedge core_clk);
    chk("adc on", adc_switch_on, 1'h1);
    reset = 1'h1;
    repeat (2) @(negedge core_clk);
    reset = 1'h0;
    @(negedge core_clk);
    chk("sel_state", sel_state, 20'h0);
    // gpio input route on every released pad
    board_lvl = 5'h0a;
    repeat (5) @(negedge core_clk);
    chk("gpio_in", gpio_in, 5'h0a);
    stop_test();
  end
endmodule

// File: pad_mux_pkg.sv
package pad_mux_pkg;
  // pad function encodings
  localparam logic [3:0] SEL_GPIO = 4'h0;
  localparam logic [3:0] SEL_1 = 4'h1;
  localparam logic [3:0] SEL_3 = 4'h3;
  localparam logic [3:0] SEL_4 = 4'h4;
  localparam logic [3:0] SEL_5 = 4'h5;
  localparam logic [3:0] SEL_6 = 4'h6;
  localparam logic [3:0] SEL_7 = 4'h7;
  localparam logic [3:0] SEL_12 = 4'hc;
  localparam logic [3:0] SEL_13 = 4'hd;
  localparam logic [3:0] SEL_RESET = 4'h0;
  localparam int NUM_PADS = 5;
  // sleep pad-state choices
  localparam logic [1:0] PS_HIZ = 2'h0;
  localparam logic [1:0] PS_PULL = 2'h1;
  localparam logic [1:0] PS_DRIVE = 2'h2;
  localparam logic [1:0] PS_RESET = 2'h0;
  // driver kind type; the decode does not use it
  typedef enum {
    drv_none_type,
    drv_push_type,
    drv_open_type,
    drv_input_type
  } drv_kind_type;
endpackage
